// ---- ssc_bus_pacer.sv ----
`default_nettype none
module ssc_bus_pacer (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Load request
  input wire logic start_in,
  input wire logic [3:0] reads_in,
  input wire logic [3:0] writes_in,
  // Bus cycle starts
  output var logic rd_out,
  output var logic wr_out
);

  ssc_pkg::ssc_pacer_type st_ff;
  ssc_pkg::ssc_pacer_type nxt_st;
  logic [3:0] rl;
  logic [3:0] wl;
  logic [1:0] ph;

  // Reads first, then writes, one bus cycle each
  always_comb begin
    rl = start_in ? reads_in : st_ff.rd_left;
    wl = start_in ? writes_in : st_ff.wr_left;
    ph = start_in ? 2'h0 : st_ff.phase;
    nxt_st = st_ff;
    nxt_st.rd = 1'b0;
    nxt_st.wr = 1'b0;
    nxt_st.rd_left = rl;
    nxt_st.wr_left = wl;
    nxt_st.phase = ph;
    if (ph != 2'h0) begin
      nxt_st.phase = 2'(ph - 2'h1);
    end else if (rl != 4'h0) begin
      nxt_st.rd = 1'b1;
      nxt_st.rd_left = 4'(rl - 4'h1);
      nxt_st.phase = ssc_pkg::BUS_PHASE_LAST;
    end else if (wl != 4'h0) begin
      nxt_st.wr = 1'b1;
      nxt_st.wr_left = 4'(wl - 4'h1);
      nxt_st.phase = ssc_pkg::BUS_PHASE_LAST;
    end
  end

  // State register
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_out = st_ff.rd;
  assign wr_out = st_ff.wr;

endmodule
`default_nettype wire

// ---- ssc_mem_model.sv ----
`default_nettype none
module ssc_mem_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Bench side
  input wire logic clear_in,
  output var logic [7:0] reads_out,
  output var logic [7:0] writes_out,
  output var logic gap_bad_out,
  // Bus cycle starts
  input wire logic bus_read_in,
  input wire logic bus_write_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] gap_ff;
  logic cyc;

  // Any bus cycle start
  assign cyc = bus_read_in | bus_write_in;

  // ----------------------------------------
  // Zero wait memory: one cycle holds the bus for four clocks
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reads_out <= 8'h00;
      writes_out <= 8'h00;
      gap_bad_out <= 1'b0;
      gap_ff <= 3'h7;
    end else begin
      reads_out <= clear_in ? 8'h00 : reads_out + 8'(bus_read_in);
      writes_out <= clear_in ? 8'h00 : writes_out + 8'(bus_write_in);
      if (cyc && gap_ff < 3'h3) begin
        gap_bad_out <= 1'b1;
      end
      gap_ff <= cyc ? 3'h0 : (gap_ff == 3'h7 ? gap_ff : gap_ff + 3'h1);
    end
  end
endmodule
`default_nettype wire

// ---- ssc_pkg.sv ----
`default_nettype none
package ssc_pkg;

  // ----------------------------------------
  // Clock and bus timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int BUS_CYCLE_NS = 400;
  localparam int BUS_CYCLE_CLKS =
    (BUS_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] BUS_PHASE_LAST = 2'(BUS_CYCLE_CLKS - 1);

  // ----------------------------------------
  // Execution figures in clock periods and bus read counts
  // ----------------------------------------
  localparam logic [8:0] SIGNED_DIVIDE_OP_CLKS = 9'h07A;
  localparam logic [8:0] UNSIGNED_DIVIDE_OP_CLKS = 9'h06C;
  localparam logic [8:0] MUL_MAX_CLKS = 9'h02A;
  localparam logic [8:0] AREG_SHORT_CLKS = 9'h008;
  localparam logic [8:0] AREG_LONG_CLKS = 9'h006;
  localparam logic [8:0] PREDEC_LOOP_CLKS = 9'h002;
  localparam logic [8:0] IMM_WORD_CLKS = 9'h004;
  localparam logic [8:0] LOOP_TRUE_CLKS = 9'h006;
  localparam logic [8:0] LOOP_EXP_CLKS = 9'h004;
  localparam logic [8:0] LOOP_CMP_EXP_CLKS = 9'h002;
  localparam logic [3:0] LOOP_TERM_READS = 4'h2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    add_op = 4'h0, and_op = 4'h1, cmp_op = 4'h2,
    signed_divide_op = 4'h3, unsigned_divide_op = 4'h4,
    exclusive_or_op = 4'h5, signed_multiply_op = 4'h6,
    unsigned_multiply_op = 4'h7, or_op = 4'h8, sub_op = 4'h9
  } ssc_op_type;

  typedef enum logic [1:0] {
    size_byte = 2'h0, size_word = 2'h1, size_long = 2'h2
  } ssc_size_type;

  typedef enum logic [1:0] {
    address_register_operand = 2'h0,
    data_register_operand = 2'h1,
    effective_address_operand = 2'h2
  } ssc_dest_type;

  typedef enum logic [2:0] {
    mode_dreg = 3'h0, mode_areg = 3'h1, mode_ind = 3'h2,
    mode_postinc = 3'h3, mode_predec = 3'h4, mode_other = 3'h5
  } ssc_mode_type;

  typedef enum logic [1:0] {
    loop_continued = 2'h0, loop_cc_true = 2'h1, loop_expired = 2'h2
  } ssc_loop_case_type;

  typedef enum logic {
    st_idle = 1'b0, st_run = 1'b1
  } ssc_state_type;

  typedef struct packed {
    logic [8:0] clocks;
    logic [3:0] reads;
    logic [3:0] writes;
  } ssc_timing_type;

  typedef struct packed {
    ssc_op_type op;
    ssc_size_type size;
    ssc_dest_type dest;
    ssc_mode_type mode;
    logic loop_mode;
    ssc_loop_case_type loop_case;
    logic [1:0] imm_words;
    ssc_timing_type ea_cost;
  } ssc_req_type;

  typedef struct packed {
    ssc_timing_type t;
    logic legal;
    logic ea_plus;
  } ssc_entry_type;

  typedef struct packed {
    ssc_state_type state;
    logic [8:0] left;
    ssc_timing_type result;
    logic busy;
    logic done;
    logic illegal;
  } ssc_seq_type;

  typedef struct packed {
    logic [1:0] phase;
    logic [3:0] rd_left;
    logic [3:0] wr_left;
    logic rd;
    logic wr;
  } ssc_pacer_type;

endpackage
`default_nettype wire

// ---- ssc_sequencer.sv ----
// Functional notes
// - Each figure covers the operation, the result store and the next prefetch.
// - Each figure is a clock total plus a count of bus reads and bus writes.
// - Entries that need it get the addressing clocks, reads and writes added.
// - Loop mode allows only indirect, postincrement or predecrement, and predecrement adds two clocks.
// - Exclusive-or into a data register accepts only a data register source.
// - An address register destination allows word and long sizes only.
// - Adding to or subtracting from an address register takes 8 clocks short and 6 long, one read.
// - Signed divide takes at most 122 clocks and one read plus addressing cost.
// - Unsigned divide takes at most 108 clocks and one read plus addressing cost.
// - Multiply takes at most 42 clocks and one read plus addressing cost.
// - Immediate extension words are fetched within the counted time.
`default_nettype none
module ssc_sequencer (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Operation request
  input wire logic start_in,
  input wire ssc_pkg::ssc_req_type req_in,
  // Sequencer status
  output var logic busy_out,
  output var logic done_out,
  output var logic illegal_out,
  output var ssc_pkg::ssc_timing_type result_out,
  // Bus cycle starts
  output var logic bus_read_out,
  output var logic bus_write_out
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  ssc_pkg::ssc_seq_type st_ff;
  ssc_pkg::ssc_seq_type nxt_st;
  ssc_pkg::ssc_entry_type entry;
  ssc_pkg::ssc_timing_type total;
  logic idle;
  logic accept;
  logic refuse;
  logic [8:0] imm_clks;

  // ----------------------------------------
  // Cost lookup
  // ----------------------------------------
  ssc_timing_table u_table (
    .req_in(req_in),
    .entry_out(entry)
  );

  // ----------------------------------------
  // Request handling
  // ----------------------------------------

  // Request is taken only while idle
  assign idle = (st_ff.state == ssc_pkg::st_idle);
  assign accept = start_in && idle && entry.legal;
  assign refuse = start_in && idle && !entry.legal;

  // Extension word fetches add clocks and reads
  assign imm_clks = 9'(9'(req_in.imm_words) * ssc_pkg::IMM_WORD_CLKS);

  // Total cost of the taken operation
  always_comb begin
    total = entry.t;
    if (entry.ea_plus) begin
      total.clocks = 9'(total.clocks + req_in.ea_cost.clocks);
      total.reads = 4'(total.reads + req_in.ea_cost.reads);
      total.writes = 4'(total.writes + req_in.ea_cost.writes);
    end
    if (!req_in.loop_mode) begin
      total.clocks = 9'(total.clocks + imm_clks);
      total.reads = 4'(total.reads + 4'(req_in.imm_words));
    end
  end

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------

  // Count the clock periods of the operation
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.illegal = refuse;
    unique case (st_ff.state)
      ssc_pkg::st_idle: begin
        if (accept) begin
          nxt_st.state = ssc_pkg::st_run;
          nxt_st.left = 9'(total.clocks - 9'h001);
          nxt_st.result = total;
          nxt_st.busy = 1'b1;
        end
      end
      ssc_pkg::st_run: begin
        if (st_ff.left == 9'h000) begin
          nxt_st.state = ssc_pkg::st_idle;
          nxt_st.busy = 1'b0;
          nxt_st.done = 1'b1;
        end else begin
          nxt_st.left = 9'(st_ff.left - 9'h001);
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Registered status outputs
  assign busy_out = st_ff.busy;
  assign done_out = st_ff.done;
  assign illegal_out = st_ff.illegal;
  assign result_out = st_ff.result;

  // ----------------------------------------
  // Bus cycle pacing
  // ----------------------------------------
  ssc_bus_pacer u_pacer (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .start_in(accept),
    .reads_in(total.reads),
    .writes_in(total.writes),
    .rd_out(bus_read_out),
    .wr_out(bus_write_out)
  );

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  logic [8:0] chk_cycles;
  logic [3:0] chk_reads;
  logic [3:0] chk_writes;

  // Count busy cycles and bus cycles of one operation
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      chk_cycles <= '0;
      chk_reads <= '0;
      chk_writes <= '0;
    end else if (accept) begin
      chk_cycles <= '0;
      chk_reads <= '0;
      chk_writes <= '0;
    end else begin
      if (busy_out)
        chk_cycles <= 9'(chk_cycles + 9'h001);
      if (bus_read_out)
        chk_reads <= 4'(chk_reads + 4'h1);
      if (bus_write_out)
        chk_writes <= 4'(chk_writes + 4'h1);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);

  // Plain request outside loop mode with no extension words, addressing cost added except for exclusive-or into a data register
  logic plain;
  assign plain = accept && !req_in.loop_mode &&
                 (req_in.imm_words == 2'h0);

  a_busy_length: assert property (
    $rose(done_out) |-> chk_cycles == result_out.clocks)
    else $error("busy time differs from clock total");

  a_read_count: assert property (
    $rose(done_out) |-> chk_reads == result_out.reads)
    else $error("read cycles differ from read count");

  a_write_count: assert property (
    $rose(done_out) |-> chk_writes == result_out.writes)
    else $error("write cycles differ from write count");

  a_ea_added: assert property (
    plain && req_in.op == ssc_pkg::add_op &&
    req_in.dest == ssc_pkg::data_register_operand &&
    req_in.size == ssc_pkg::size_word |=>
    result_out.clocks == 9'(9'h004 + $past(req_in.ea_cost.clocks)) &&
    result_out.reads == 4'(4'h1 + $past(req_in.ea_cost.reads)))
    else $error("addressing cost not added");

  a_loop_modes: assert property (
    start_in && idle && req_in.loop_mode &&
    (req_in.mode == ssc_pkg::mode_dreg ||
     req_in.mode == ssc_pkg::mode_other) |=>
    illegal_out && !busy_out)
    else $error("loop mode took a forbidden addressing mode");

  a_loop_predec: assert property (
    accept && req_in.loop_mode && req_in.op == ssc_pkg::add_op &&
    req_in.dest == ssc_pkg::effective_address_operand &&
    req_in.size == ssc_pkg::size_word &&
    req_in.loop_case == ssc_pkg::loop_continued &&
    req_in.mode == ssc_pkg::mode_predec |=>
    result_out.clocks == 9'h012)
    else $error("predecrement loop time wrong");

  a_eor_source: assert property (
    start_in && idle && req_in.op == ssc_pkg::exclusive_or_op &&
    req_in.dest == ssc_pkg::data_register_operand &&
    req_in.mode != ssc_pkg::mode_dreg |=>
    illegal_out && !busy_out)
    else $error("exclusive-or took a bad source");

  a_areg_byte: assert property (
    start_in && idle && req_in.size == ssc_pkg::size_byte &&
    req_in.dest == ssc_pkg::address_register_operand |=>
    illegal_out ##1 !busy_out)
    else $error("byte size taken for address destination");

  a_areg_word: assert property (
    plain && req_in.op == ssc_pkg::sub_op &&
    req_in.dest == ssc_pkg::address_register_operand &&
    req_in.size == ssc_pkg::size_word |=>
    (result_out.clocks == 9'(9'h008 + $past(req_in.ea_cost.clocks)))
    ##0 busy_out[*8])
    else $error("address register add time wrong");

  a_areg_cost: assert property (
    plain && (req_in.op == ssc_pkg::add_op ||
              req_in.op == ssc_pkg::sub_op) &&
    req_in.dest == ssc_pkg::address_register_operand &&
    req_in.size == ssc_pkg::size_long |=>
    result_out.clocks == 9'(9'h006 + $past(req_in.ea_cost.clocks)))
    else $error("long address register add time wrong");

  a_div_signed: assert property (
    plain && req_in.op == ssc_pkg::signed_divide_op |=>
    result_out.clocks ==
      9'(ssc_pkg::SIGNED_DIVIDE_OP_CLKS + $past(req_in.ea_cost.clocks)))
    else $error("signed divide time wrong");

  a_div_unsigned: assert property (
    plain && req_in.op == ssc_pkg::unsigned_divide_op |=>
    result_out.clocks ==
      9'(ssc_pkg::UNSIGNED_DIVIDE_OP_CLKS + $past(req_in.ea_cost.clocks)))
    else $error("unsigned divide time wrong");

  a_mul_bound: assert property (
    plain && (req_in.op == ssc_pkg::signed_multiply_op ||
              req_in.op == ssc_pkg::unsigned_multiply_op) |=>
    result_out.clocks <=
      9'(ssc_pkg::MUL_MAX_CLKS + $past(req_in.ea_cost.clocks)))
    else $error("multiply exceeds its bound");

  a_imm_words: assert property (
    accept && !req_in.loop_mode && req_in.imm_words == 2'h2 &&
    req_in.op == ssc_pkg::or_op &&
    req_in.dest == ssc_pkg::data_register_operand &&
    req_in.size == ssc_pkg::size_long |=>
    result_out.clocks == 9'(9'h00E + $past(req_in.ea_cost.clocks)) &&
    result_out.reads == 4'(4'h3 + $past(req_in.ea_cost.reads)))
    else $error("extension words not counted");

  a_bus_spacing: assert property (
    bus_read_out |=> !(bus_read_out || bus_write_out) [*3])
    else $error("bus cycles closer than one full cycle");

  a_done_pulse: assert property (
    done_out |=> !done_out && (!busy_out || $past(accept)))
    else $error("done held or busy after done");

  // ----------------------------------------
  // Covers
  // ----------------------------------------
  c_divide_run: cover property (
    accept && req_in.op == ssc_pkg::signed_divide_op);

  c_loop_expired: cover property (
    accept && req_in.loop_mode &&
    req_in.loop_case == ssc_pkg::loop_expired);

  c_refused: cover property (illegal_out);

  c_memory_write: cover property (
    bus_write_out ##[1:40] done_out);

endmodule
`default_nettype wire

// ---- ssc_timing_table.sv ----
`default_nettype none
module ssc_timing_table (
  // Requested operation
  input wire ssc_pkg::ssc_req_type req_in,
  // Looked-up cost and legality
  output var ssc_pkg::ssc_entry_type entry_out
);

  logic wide;
  logic [2:0] allow;
  logic mode_ok;
  logic is_cmp;

  // ----------------------------------------
  // Cost lookup
  // ----------------------------------------
  always_comb begin
    wide = (req_in.size == ssc_pkg::size_long);
    is_cmp = (req_in.op == ssc_pkg::cmp_op);
    mode_ok = (req_in.mode == ssc_pkg::mode_ind) ||
              (req_in.mode == ssc_pkg::mode_postinc) ||
              (req_in.mode == ssc_pkg::mode_predec);
    entry_out = '0;
    // Permitted destinations: address, data, memory
    unique case (req_in.op)
      ssc_pkg::add_op, ssc_pkg::sub_op: allow = 3'h7;
      ssc_pkg::and_op, ssc_pkg::or_op: allow = 3'h3;
      ssc_pkg::cmp_op: allow = 3'h6;
      ssc_pkg::exclusive_or_op: allow = req_in.loop_mode ? 3'h1 : 3'h3;
      ssc_pkg::signed_divide_op, ssc_pkg::unsigned_divide_op,
      ssc_pkg::signed_multiply_op, ssc_pkg::unsigned_multiply_op:
        allow = req_in.loop_mode ? 3'h0 : 3'h2;
      default: allow = 3'h0;
    endcase
    entry_out.t.reads = (req_in.loop_mode && wide) ? 4'h2 : 4'h1;
    entry_out.ea_plus = !req_in.loop_mode;
    unique case (req_in.dest)
      ssc_pkg::address_register_operand: begin
        entry_out.legal = allow[2] &&
                          (req_in.size != ssc_pkg::size_byte);
        if (req_in.loop_mode)
          entry_out.t.clocks = wide ? 9'h016 : 9'h012;
        else if (is_cmp)
          entry_out.t.clocks = 9'h006;
        else
          entry_out.t.clocks = wide ? ssc_pkg::AREG_LONG_CLKS
                                    : ssc_pkg::AREG_SHORT_CLKS;
      end
      ssc_pkg::data_register_operand: begin
        entry_out.legal = allow[1];
        entry_out.t.clocks = wide ? 9'h006 : 9'h004;
        if (req_in.loop_mode) begin
          entry_out.t.clocks = wide ? 9'h016 : 9'h010;
          if (req_in.op == ssc_pkg::sub_op && wide)
            entry_out.t.clocks = 9'h014;
        end else begin
          unique case (req_in.op)
            ssc_pkg::signed_divide_op:
              entry_out.t.clocks = ssc_pkg::SIGNED_DIVIDE_OP_CLKS;
            ssc_pkg::unsigned_divide_op:
              entry_out.t.clocks = ssc_pkg::UNSIGNED_DIVIDE_OP_CLKS;
            ssc_pkg::signed_multiply_op, ssc_pkg::unsigned_multiply_op:
              entry_out.t.clocks = ssc_pkg::MUL_MAX_CLKS;
            ssc_pkg::exclusive_or_op: begin
              entry_out.legal = (req_in.mode == ssc_pkg::mode_dreg);
              entry_out.ea_plus = 1'b0;
            end
            default: entry_out.ea_plus = 1'b1;
          endcase
        end
      end
      ssc_pkg::effective_address_operand: begin
        entry_out.legal = allow[0];
        entry_out.t.writes = wide ? 4'h2 : 4'h1;
        if (req_in.loop_mode)
          entry_out.t.clocks = wide ? 9'h018 : 9'h010;
        else
          entry_out.t.clocks = wide ? 9'h00C : 9'h008;
      end
      default: entry_out.legal = 1'b0;
    endcase
    // Size code 3 names no operand size
    if (req_in.size > ssc_pkg::size_long)
      entry_out.legal = 1'b0;
    // Loop mode corrections and addressing limits
    if (req_in.loop_mode) begin
      if (is_cmp)
        entry_out.t.clocks = wide ? 9'h012 : 9'h00C;
      if (!mode_ok || req_in.imm_words != 2'h0)
        entry_out.legal = 1'b0;
      if (req_in.mode == ssc_pkg::mode_predec)
        entry_out.t.clocks = 9'(entry_out.t.clocks +
                                ssc_pkg::PREDEC_LOOP_CLKS);
      unique case (req_in.loop_case)
        ssc_pkg::loop_continued: entry_out.t.clocks = entry_out.t.clocks;
        ssc_pkg::loop_cc_true: begin
          entry_out.t.clocks = 9'(entry_out.t.clocks +
                                  ssc_pkg::LOOP_TRUE_CLKS);
          entry_out.t.reads = 4'(entry_out.t.reads +
                                 ssc_pkg::LOOP_TERM_READS);
        end
        ssc_pkg::loop_expired: begin
          entry_out.t.clocks = 9'(entry_out.t.clocks +
            ((is_cmp && wide) ? ssc_pkg::LOOP_CMP_EXP_CLKS
                              : ssc_pkg::LOOP_EXP_CLKS));
          entry_out.t.reads = 4'(entry_out.t.reads +
                                 ssc_pkg::LOOP_TERM_READS);
        end
        default: entry_out.legal = 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- standard_op_cycle_timing_bench.sv ----
`default_nettype none
module standard_op_cycle_timing_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic start_in = 1'b0;
  logic clear = 1'b0;
  ssc_pkg::ssc_req_type req_in = '0;
  ssc_pkg::ssc_timing_type result, last_res = '0;
  logic busy, done, illegal, rd, wr, gap_bad;
  logic [7:0] n_rd, n_wr;
  logic [16:0] ea8 = {9'h008, 4'h2, 4'h0};
  int fails = 0;
  int checks_done = 0;
  integer seed = 32'h33965C09;

  ssc_sequencer dut_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .start_in(start_in), .req_in(req_in), .busy_out(busy),
    .done_out(done), .illegal_out(illegal), .result_out(result),
    .bus_read_out(rd), .bus_write_out(wr));
  ssc_mem_model mem_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .clear_in(clear), .reads_out(n_rd), .writes_out(n_wr),
    .gap_bad_out(gap_bad), .bus_read_in(rd), .bus_write_in(wr));

  // 10 MHz clock
  initial begin
    forever #50 clock_in = ~clock_in;
  end

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task automatic chk_v(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_t(input string what,
      input ssc_pkg::ssc_timing_type exp, input ssc_pkg::ssc_timing_type got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Request building and expected cost
  // ----------------------------------------
  function automatic ssc_pkg::ssc_req_type mk(input logic [3:0] op,
      input logic [1:0] sz, input logic [1:0] ds, input logic [2:0] md,
      input logic lp, input logic [1:0] lc, input logic [1:0] im,
      input logic [16:0] ea);
    return {op, sz, ds, md, lp, lc, im, ea};
  endfunction

  function automatic ssc_pkg::ssc_timing_type exp_cost(
      input ssc_pkg::ssc_req_type r, output logic ok);
    ssc_pkg::ssc_timing_type t;
    logic sh;
    logic eor_d;
    sh = (r.size != ssc_pkg::size_long);
    eor_d = (r.op == ssc_pkg::exclusive_or_op) && (r.dest == 2'h1);
    t = {9'h000, 4'h1, 4'h0};
    ok = (r.size != 2'h3);
    if (r.dest == 2'h0) begin
      ok &= (r.op inside {4'h0, 4'h2, 4'h9}) && (r.size != 2'h0);
      t.clocks = (sh && r.op != 4'h2) ? 9'h008 : 9'h006;
    end else if (r.dest == 2'h1) begin
      case (r.op)
        4'h3: t.clocks = 9'h07A;
        4'h4: t.clocks = 9'h06C;
        4'h6, 4'h7: t.clocks = 9'h02A;
        default: t.clocks = sh ? 9'h004 : 9'h006;
      endcase
      ok &= !eor_d || (r.mode == ssc_pkg::mode_dreg);
    end else begin
      ok &= (r.op inside {4'h0, 4'h1, 4'h5, 4'h8, 4'h9});
      t.clocks = sh ? 9'h008 : 9'h00C;
      t.writes = sh ? 4'h1 : 4'h2;
    end
    if (!eor_d) begin
      t = {t.clocks + r.ea_cost.clocks, t.reads + r.ea_cost.reads,
        t.writes + r.ea_cost.writes};
    end
    t.clocks += 9'(r.imm_words) * 9'h004;
    t.reads += 4'(r.imm_words);
    return t;
  endfunction

  // ----------------------------------------
  // One request, measured at the ports
  // ----------------------------------------
  task automatic run_op(input ssc_pkg::ssc_req_type r,
      input ssc_pkg::ssc_timing_type t, input logic ok, input logic poke);
    int n;
    int rd1;
    int wr1;
    n = 0;
    rd1 = 0;
    wr1 = 0;
    @(posedge clock_in);
    start_in <= 1'b1;
    req_in <= r;
    clear <= 1'b1;
    @(posedge clock_in);
    start_in <= 1'b0;
    clear <= 1'b0;
    // Refusal pulse stands in the cycle right after the take edge
    if (!ok) begin
      #1;
      chk_v("illegal", 16'h1, 16'(illegal));
      chk_v("busy", 16'h0, 16'(busy));
      chk_t("held result", last_res, result);
      return;
    end
    // Sample cycle k after the take edge, first busy cycle included
    for (int k = 1; k < 600; k++) begin
      #1;
      if (rd === 1'b1 && rd1 == 0) rd1 = k;
      if (wr === 1'b1 && wr1 == 0) wr1 = k;
      if (busy === 1'b1) n++;
      if (done === 1'b1) break;
      @(posedge clock_in);
      start_in <= poke && (k == 2);
    end
    chk_v("busy cycles", 16'(t.clocks), 16'(n));
    chk_t("result", t, result);
    chk_v("reads", 16'(t.reads), 16'(n_rd));
    chk_v("writes", 16'(t.writes), 16'(n_wr));
    chk_v("first read", 16'h1, 16'(rd1));
    if (t.writes != 4'h0) begin
      chk_v("first write", 16'(4 * t.reads + 1), 16'(wr1));
    end
    last_res = result;
  endtask

  task automatic tc(input ssc_pkg::ssc_req_type r);
    ssc_pkg::ssc_timing_type t;
    logic ok;
    t = exp_cost(r, ok);
    run_op(r, t, ok, 1'b0);
  endtask

  // Hang guard, well beyond the planned run
  initial begin
    #(60000 * 100);
    fails++;
    final_report();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    ssc_pkg::ssc_req_type r;
    logic [31:0] v;
    repeat (20) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    tc(mk(4'h0, 2'h0, 2'h0, 3'h2, 1'b0, 2'h0, 2'h0, ea8));
    run_op(mk(4'h0, 2'h1, 2'h2, 3'h0, 1'b0, 2'h0, 2'h0, 17'h00000),
      {9'h008, 4'h1, 4'h1}, 1'b1, 1'b1);
    tc(mk(4'h9, 2'h1, 2'h0, 3'h2, 1'b0, 2'h0, 2'h0, ea8));
    tc(mk(4'h9, 2'h2, 2'h0, 3'h2, 1'b0, 2'h0, 2'h0, ea8));
    tc(mk(4'h3, 2'h1, 2'h1, 3'h2, 1'b0, 2'h0, 2'h0, ea8));
    tc(mk(4'h4, 2'h1, 2'h1, 3'h2, 1'b0, 2'h0, 2'h0, ea8));
    tc(mk(4'h6, 2'h1, 2'h1, 3'h3, 1'b0, 2'h0, 2'h0, ea8));
    tc(mk(4'h7, 2'h1, 2'h1, 3'h4, 1'b0, 2'h0, 2'h0, ea8));
    tc(mk(4'h5, 2'h1, 2'h1, 3'h2, 1'b0, 2'h0, 2'h0, ea8));
    tc(mk(4'h5, 2'h2, 2'h1, 3'h0, 1'b0, 2'h0, 2'h0, ea8));
    tc(mk(4'h8, 2'h2, 2'h1, 3'h0, 1'b0, 2'h0, 2'h2, ea8));
    tc(mk(4'h0, 2'h3, 2'h1, 3'h0, 1'b0, 2'h0, 2'h0, ea8));
    // Loop mode cases, addressing cost ignored
    run_op(mk(4'h0, 2'h1, 2'h1, 3'h2, 1'b1, 2'h0, 2'h0, ea8),
      {9'h010, 4'h1, 4'h0}, 1'b1, 1'b0);
    run_op(mk(4'h0, 2'h1, 2'h1, 3'h4, 1'b1, 2'h0, 2'h0, ea8),
      {9'h012, 4'h1, 4'h0}, 1'b1, 1'b0);
    run_op(mk(4'h0, 2'h1, 2'h2, 3'h4, 1'b1, 2'h0, 2'h0, ea8),
      {9'h012, 4'h1, 4'h1}, 1'b1, 1'b0);
    run_op(mk(4'h0, 2'h1, 2'h1, 3'h3, 1'b1, 2'h1, 2'h0, ea8),
      {9'h016, 4'h3, 4'h0}, 1'b1, 1'b0);
    run_op(mk(4'h9, 2'h2, 2'h1, 3'h2, 1'b1, 2'h2, 2'h0, ea8),
      {9'h018, 4'h4, 4'h0}, 1'b1, 1'b0);
    run_op(mk(4'h0, 2'h1, 2'h1, 3'h0, 1'b1, 2'h0, 2'h0, ea8),
      '0, 1'b0, 1'b0);
    run_op(mk(4'h3, 2'h1, 2'h1, 3'h2, 1'b1, 2'h0, 2'h0, ea8),
      '0, 1'b0, 1'b0);
    // Random requests outside loop mode
    repeat (40) begin
      v = $random(seed);
      r = '0;
      r.op = ssc_pkg::ssc_op_type'(4'(v[7:0] % 10));
      r.size = ssc_pkg::ssc_size_type'(2'(v[9:8] % 3));
      r.dest = ssc_pkg::ssc_dest_type'(2'(v[11:10] % 3));
      r.mode = ssc_pkg::ssc_mode_type'(3'(v[14:12] % 6));
      if (r.mode == ssc_pkg::mode_areg) r.mode = ssc_pkg::mode_other;
      if (r.op != ssc_pkg::exclusive_or_op) r.imm_words = 2'(v[17:16] % 3);
      r.ea_cost.reads = 4'(v[19:18] % 3);
      r.ea_cost.clocks = 9'(4 * r.ea_cost.reads + 2 * v[21:20]);
      tc(r);
    end
    repeat (4) @(posedge clock_in);
    #1;
    chk_v("bus spacing", 16'h0, 16'(gap_bad));
    final_report();
  end
endmodule
`default_nettype wire
